//--- rtl/acs_sequencer.sv
// successive-approximation converter control with apb registers
// assumes an external dac/comparator pair and a sample switch driven
// from o_dac_code and o_hold_connect, and synchronous pin levels
//
// Behaviour
// - result bytes have no reset; undefined until a conversion or write
// - completion seen by start bit clearing or by the interrupt
// - two conversion clock periods pass before the next acquisition
// - a conversion lasts exactly twelve conversion clock periods
// - three-bit select picks 2,4,8,16,32,64 oscillator periods or rc
// - holding capacitor disconnects from the pin as conversion starts
// - an output-driven selected pin is still sampled and converted
// - port readback shows zero on every analog-configured pin
// - conversion ignores direction and digital/analog configuration
// - rc conversion clock modelled as 4 us, or 6 us extended parts
// - completion loads result, clears start bit, sets done flag
// - format bit selects right or left justified result
module acs_sequencer #(
   parameter bit EXTENDED_LV = 1'b0
) (
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_reset_n,
   // apb slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // analog front end
   output logic             o_adc_enable,
   output logic [2:0]       o_channel_sel,
   output logic             o_hold_connect,
   output logic [9:0]       o_dac_code,
   input  wire logic        i_cmp_above,
   // port pins
   input  wire logic [7:0]  i_pin_level,
   // interrupt
   output logic             o_irq
);
   localparam int RC_NS = EXTENDED_LV ? acs_pkg::RC_TAD_EXT_NS : acs_pkg::RC_TAD_STD_NS;
   localparam int RC_CYCLES = RC_NS / acs_pkg::CLK_PERIOD_NS;
   // periods in a conversion and in the gap after it, for the length checks
   localparam int CONV_TADS = int'(acs_pkg::CONV_LAST_TAD) + 1;
   localparam int GAP_TADS  = int'(acs_pkg::GAP_LAST_TAD) + 1;

   if (RC_CYCLES < 2 || RC_CYCLES > 255) begin : g_chk
      $error("acs_sequencer: rc period does not fit the timer");
   end

   typedef struct packed {
      acs_pkg::acs_state_type fsm;
      logic [7:0]             ctrl0;
      logic [7:0]             ctrl1;
      logic                   done_flag;
      logic                   irq_mask;
      logic [9:0]             trial;
      logic [3:0]             tad_idx;
      logic [31:0]            rdata;
   } acs_regs_type;

   localparam acs_regs_type REGS_RST = '{
      fsm:   acs_pkg::ACS_IDLE,
      ctrl0: acs_pkg::CTRL0_RST,
      ctrl1: acs_pkg::CTRL1_RST,
      default: '0};

   acs_regs_type r_reg;
   acs_regs_type r_next;
   logic [7:0]   result_high_byte;
   logic [7:0]   result_low_byte;
   logic [2:0]   clk_sel;
   logic [7:0]   tad_limit;
   logic         tick;
   logic         timer_clear;
   logic         is_idle;
   logic         is_conv;
   logic         is_gap;
   logic         go;
   logic         on;
   logic         fmt;
   logic         conv_done;
   logic         gap_done;
   logic         apb_setup;
   logic         apb_access;
   logic         apb_wr;
   logic         hit_any;
   logic [7:0]   analog_mask;
   logic [7:0]   port_read;
   logic [3:0]   bit_pos;
   logic [15:0]  cyc_reg;

   assign clk_sel     = {r_reg.ctrl1[acs_pkg::CSEL_HI_BIT],
                         r_reg.ctrl0[acs_pkg::CSEL_LO_MSB:acs_pkg::CSEL_LO_LSB]};
   assign is_idle     = (r_reg.fsm == acs_pkg::ACS_IDLE);
   assign is_conv     = (r_reg.fsm == acs_pkg::ACS_CONV);
   assign is_gap      = (r_reg.fsm == acs_pkg::ACS_GAP);
   assign go          = r_reg.ctrl0[acs_pkg::GO_BIT];
   assign on          = r_reg.ctrl0[acs_pkg::ON_BIT];
   assign fmt         = r_reg.ctrl1[acs_pkg::FMT_BIT];
   assign apb_setup   = i_psel && !i_penable;
   assign apb_access  = i_psel && i_penable;
   assign apb_wr      = apb_access && i_pwrite;
   assign analog_mask = acs_pkg::ANALOG_MAP[r_reg.ctrl1[acs_pkg::PCFG_MSB:acs_pkg::PCFG_LSB]];
   assign port_read   = i_pin_level & ~analog_mask;
   assign bit_pos     = acs_pkg::SAR_LAST_TAD - r_reg.tad_idx;

   assign conv_done = is_conv && go && on && tick && (r_reg.tad_idx == acs_pkg::CONV_LAST_TAD);
   assign gap_done  = is_gap && tick && (r_reg.tad_idx == acs_pkg::GAP_LAST_TAD);

   always_comb begin
      case (clk_sel)
         acs_pkg::SEL_DIV2:  tad_limit = acs_pkg::DIV2;
         acs_pkg::SEL_DIV4:  tad_limit = acs_pkg::DIV4;
         acs_pkg::SEL_DIV8:  tad_limit = acs_pkg::DIV8;
         acs_pkg::SEL_DIV16: tad_limit = acs_pkg::DIV16;
         acs_pkg::SEL_DIV32: tad_limit = acs_pkg::DIV32;
         acs_pkg::SEL_DIV64: tad_limit = acs_pkg::DIV64;
         // rc source modelled by its typical period
         default:            tad_limit = 8'(RC_CYCLES);
      endcase
   end

   always_comb begin
      case (i_paddr)
         acs_pkg::OFS_CTRL0, acs_pkg::OFS_CTRL1, acs_pkg::OFS_RESH, acs_pkg::OFS_RESL,
         acs_pkg::OFS_STAT, acs_pkg::OFS_MASK, acs_pkg::OFS_PORT: hit_any = 1'b1;
         default: hit_any = 1'b0;
      endcase
   end

   // each phase starts its periods from a fresh count
   assign timer_clear = !(is_conv || is_gap) || (r_next.fsm != r_reg.fsm);

   acs_tad_timer #(
      .CNT_W (8)
   ) u_tad_timer (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .i_clear   (timer_clear),
      .i_limit   (tad_limit),
      .o_tick    (tick)
   );

   always_comb begin
      r_next = r_reg;
      case (r_reg.fsm)
         acs_pkg::ACS_IDLE: begin
            if (go && on) begin
               r_next.fsm     = acs_pkg::ACS_CONV;
               r_next.trial   = acs_pkg::SAR_MSB_CODE;
               r_next.tad_idx = '0;
            end
         end
         acs_pkg::ACS_CONV: begin
            if (!go || !on) begin
               // abort keeps the previous result
               r_next.fsm     = acs_pkg::ACS_GAP;
               r_next.tad_idx = '0;
            end else if (tick) begin
               r_next.tad_idx = r_reg.tad_idx + 4'h1;
               // one bit per period, msb first
               if (r_reg.tad_idx >= acs_pkg::SAR_FIRST_TAD && r_reg.tad_idx <= acs_pkg::SAR_LAST_TAD) begin
                  // comparator input is never gated by pin setup
                  r_next.trial[bit_pos] = i_cmp_above;
                  if (bit_pos != 4'h0) begin
                     r_next.trial[bit_pos - 4'h1] = 1'b1;
                  end
               end
               if (conv_done) begin
                  r_next.fsm                   = acs_pkg::ACS_GAP;
                  r_next.tad_idx               = '0;
                  r_next.ctrl0[acs_pkg::GO_BIT] = 1'b0;
               end
            end
         end
         acs_pkg::ACS_GAP: begin
            if (!on || gap_done) begin
               r_next.fsm = acs_pkg::ACS_IDLE;
            end else if (tick) begin
               r_next.tad_idx = r_reg.tad_idx + 4'h1;
            end
         end
         default: begin
            r_next.fsm = acs_pkg::ACS_IDLE;
         end
      endcase

      // done flag; a completion beats a read-clear
      r_next.done_flag = (r_reg.done_flag & ~(apb_access && !i_pwrite && i_paddr == acs_pkg::OFS_STAT
                          && r_reg.rdata[0])) | conv_done;

      // read data is captured in setup so pready can rise at once
      if (apb_setup && !i_pwrite) begin
         case (i_paddr)
            acs_pkg::OFS_CTRL0: r_next.rdata = 32'(r_reg.ctrl0);
            acs_pkg::OFS_CTRL1: r_next.rdata = 32'(r_reg.ctrl1);
            acs_pkg::OFS_RESH:  r_next.rdata = 32'(result_high_byte);
            acs_pkg::OFS_RESL:  r_next.rdata = 32'(result_low_byte);
            acs_pkg::OFS_STAT:  r_next.rdata = 32'(r_reg.done_flag);
            acs_pkg::OFS_MASK:  r_next.rdata = 32'(r_reg.irq_mask);
            acs_pkg::OFS_PORT:  r_next.rdata = 32'(port_read);
            default:            r_next.rdata = '0;
         endcase
      end

      // a software start set in the completing cycle wins over the clear
      if (apb_wr) begin
         case (i_paddr)
            acs_pkg::OFS_CTRL0: begin
               r_next.ctrl0 = i_pwdata[7:0] & acs_pkg::CTRL0_WMASK;
               // start is ignored unless the converter is already on
               r_next.ctrl0[acs_pkg::GO_BIT] = i_pwdata[acs_pkg::GO_BIT] & on;
            end
            acs_pkg::OFS_CTRL1: r_next.ctrl1 = i_pwdata[7:0] & acs_pkg::CTRL1_WMASK;
            acs_pkg::OFS_MASK:  r_next.irq_mask = i_pwdata[0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         r_reg <= REGS_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // no reset on the result bytes
   always_ff @(posedge i_mclk) begin
      if (conv_done) begin
         if (fmt) begin
            result_high_byte <= 8'(r_next.trial[9:8]);
            result_low_byte  <= r_next.trial[7:0];
         end else begin
            result_high_byte <= r_next.trial[9:2];
            result_low_byte  <= {r_next.trial[1:0], {acs_pkg::RES_PAD{1'b0}}};
         end
      end else if (apb_wr && i_paddr == acs_pkg::OFS_RESH) begin
         result_high_byte <= i_pwdata[7:0];
      end else if (apb_wr && i_paddr == acs_pkg::OFS_RESL) begin
         result_low_byte <= i_pwdata[7:0];
      end
   end

   assign o_prdata       = r_reg.rdata;
   assign o_pready       = apb_access;
   assign o_pslverr      = apb_access && !hit_any;
   assign o_adc_enable   = on;
   assign o_channel_sel  = r_reg.ctrl0[acs_pkg::CHAN_MSB:acs_pkg::CHAN_LSB];
   assign o_hold_connect = is_idle && on;
   assign o_dac_code     = r_reg.trial;
   assign o_irq          = r_reg.done_flag && r_reg.irq_mask;

   // cycles spent in the present state, read by the checks below
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cyc_reg <= '0;
      end else if (r_next.fsm != r_reg.fsm) begin
         cyc_reg <= '0;
      end else begin
         cyc_reg <= cyc_reg + 16'h1;
      end
   end

   AST_CONV_LEN: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      conv_done |-> (cyc_reg == 16'(CONV_TADS * int'(tad_limit)) - 16'h1))
      else $error("conversion did not last twelve periods");

   AST_GAP_LEN: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      gap_done |-> (cyc_reg == 16'(GAP_TADS * int'(tad_limit)) - 16'h1))
      else $error("gap after conversion not two periods");

   AST_GAP_HOLD: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      is_gap && on && !gap_done |=> is_gap && !o_hold_connect)
      else $error("acquisition resumed before the gap ended");

   AST_DONE_SEEN: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      conv_done && !apb_wr |=> !go && r_reg.done_flag && is_gap ##1 r_reg.done_flag)
      else $error("completion not signalled");

   AST_HOLD_OPEN: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      $rose(is_conv) |-> !o_hold_connect && $past(o_hold_connect))
      else $error("holding capacitor not released at start");

   AST_SAR_MSB: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      $rose(is_conv) |-> o_dac_code == acs_pkg::SAR_MSB_CODE)
      else $error("approximation did not begin at the top bit");

   AST_PORT_ZERO: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      apb_setup && !i_pwrite && i_paddr == acs_pkg::OFS_PORT |=> (o_prdata[7:0] & $past(analog_mask)) == 8'h00)
      else $error("analog pin read back high");

   AST_FMT_RIGHT: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      conv_done && fmt |=> result_high_byte[7:2] == 6'h00)
      else $error("right justified high byte not padded");

   AST_FMT_LEFT: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      conv_done && !fmt |=> result_low_byte[5:0] == 6'h00)
      else $error("left justified low byte not padded");

   AST_IRQ: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      conv_done && r_reg.irq_mask && !apb_wr |=> o_irq)
      else $error("interrupt missing after completion");

   AST_GAP_ENTRY: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      conv_done |=> is_gap && !o_hold_connect)
      else $error("no gap after a completed conversion");

   AST_ABORT_GAP: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      is_conv && on && !go |=> is_gap && !o_hold_connect)
      else $error("no gap after an aborted conversion");

   AST_RECONNECT: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      gap_done && on && !apb_wr |=> o_hold_connect)
      else $error("acquisition did not resume after the gap");

   AST_FLAG_SOURCE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      $rose(r_reg.done_flag) |-> $past(conv_done))
      else $error("done flag raised without a completed conversion");

   AST_SAR_STEP: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      is_conv && go && on && tick && r_reg.tad_idx >= acs_pkg::SAR_FIRST_TAD
      && r_reg.tad_idx <= acs_pkg::SAR_LAST_TAD |=> o_dac_code[$past(bit_pos)] == $past(i_cmp_above))
      else $error("decided bit differs from the comparator");
endmodule

//--- rtl/acs_pkg.sv
// constants, state codes and register map of the conversion sequencer
// assumes a 40 MHz system clock that is also the converter's oscillator
package acs_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_RESH  = 8'h08;
   localparam logic [7:0] OFS_RESL  = 8'h0c;
   localparam logic [7:0] OFS_STAT  = 8'h10;
   localparam logic [7:0] OFS_MASK  = 8'h14;
   localparam logic [7:0] OFS_PORT  = 8'h18;
   // converter_control_0 fields
   localparam int CSEL_LO_MSB = 7;
   localparam int CSEL_LO_LSB = 6;
   localparam int CHAN_MSB    = 5;
   localparam int CHAN_LSB    = 3;
   localparam int GO_BIT      = 2;
   localparam int ON_BIT      = 0;
   localparam logic [7:0] CTRL0_WMASK = 8'hf9;
   localparam logic [7:0] CTRL0_RST   = 8'h00;
   // converter_control_1 fields
   localparam int FMT_BIT     = 7;
   localparam int CSEL_HI_BIT = 6;
   localparam int PCFG_MSB    = 3;
   localparam int PCFG_LSB    = 0;
   localparam logic [7:0] CTRL1_WMASK = 8'hcf;
   localparam logic [7:0] CTRL1_RST   = 8'h00;
   // conversion_clock_select codes and oscillator dividers
   localparam logic [2:0] SEL_DIV2  = 3'h0;
   localparam logic [2:0] SEL_DIV4  = 3'h4;
   localparam logic [2:0] SEL_DIV8  = 3'h1;
   localparam logic [2:0] SEL_DIV16 = 3'h5;
   localparam logic [2:0] SEL_DIV32 = 3'h2;
   localparam logic [2:0] SEL_DIV64 = 3'h6;
   localparam logic [7:0] DIV2  = 8'h02;
   localparam logic [7:0] DIV4  = 8'h04;
   localparam logic [7:0] DIV8  = 8'h08;
   localparam logic [7:0] DIV16 = 8'h10;
   localparam logic [7:0] DIV32 = 8'h20;
   localparam logic [7:0] DIV64 = 8'h40;
   // system clock period and internal rc periods, typical, in ns
   localparam int CLK_PERIOD_NS = 25;
   localparam int RC_TAD_STD_NS = 4000;
   localparam int RC_TAD_EXT_NS = 6000;
   // sequence lengths in conversion clock periods
   localparam logic [3:0] CONV_LAST_TAD = 4'hb;
   localparam logic [3:0] GAP_LAST_TAD  = 4'h1;
   localparam logic [3:0] SAR_FIRST_TAD = 4'h1;
   localparam logic [3:0] SAR_LAST_TAD  = 4'ha;
   localparam logic [9:0] SAR_MSB_CODE  = 10'h200;
   localparam int RES_PAD = 6;
   // analog pins per port configuration, entry 15 first
   localparam logic [15:0][7:0] ANALOG_MAP = {
      8'h0d, 8'h01, 8'h0f, 8'h1f, 8'h3f, 8'h3f, 8'h3f, 8'hff,
      8'h00, 8'h00, 8'h0b, 8'h0b, 8'h1f, 8'h1f, 8'hff, 8'hff};
   typedef enum logic [2:0] {
      ACS_IDLE = 3'b001,
      ACS_CONV = 3'b010,
      ACS_GAP  = 3'b100
   } acs_state_type;
endpackage

//--- rtl/acs_tad_timer.sv
// conversion clock period timer: one tick every i_limit system clocks
// assumes the caller clears it whenever a new sequence phase begins
module acs_tad_timer #(
   parameter int CNT_W = 8
) (
   // clock and reset
   input  wire logic             i_mclk,
   input  wire logic             i_reset_n,
   // control
   input  wire logic             i_clear,
   input  wire logic [CNT_W-1:0] i_limit,
   // tick
   output logic                  o_tick
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } acs_tad_state_type;

   acs_tad_state_type s_reg;
   acs_tad_state_type s_next;

   if (CNT_W < 2) begin : g_chk
      $error("acs_tad_timer: CNT_W too small");
   end

   // greater-or-equal so a divider lowered mid-period cannot wrap
   assign o_tick = (s_reg.cnt >= i_limit - CNT_W'(1));

   always_comb begin
      s_next = s_reg;
      if (i_clear || o_tick) begin
         s_next.cnt = '0;
      end else begin
         s_next.cnt = s_reg.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

//--- verif/acs_analog_model.sv
// front end model: channel levels, sample switch, holding capacitor, comparator
// assumes the bench sets the channel levels and the sequencer drives the switch
module acs_analog_model (
   // clock
   input  wire logic            i_mclk,
   // switch and mux control
   input  wire logic            i_hold_connect,
   input  wire logic [2:0]      i_channel_sel,
   input  wire logic [9:0]      i_dac_code,
   // channel levels, whatever the pin direction or configuration
   input  wire logic [7:0][9:0] i_levels,
   // comparator
   output logic                 o_cmp_above
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] held_reg;
   // tracks the pin only while connected
   always_ff @(posedge i_mclk) begin
      if (i_hold_connect) begin
         held_reg <= i_levels[i_channel_sel];
      end
   end
   assign o_cmp_above = (held_reg >= i_dac_code);
endmodule

//--- verif/tb_adc_conversion_sequencer.sv
// self-checking bench of the conversion sequencer, apb master and front end model
// assumes zero or more wait states on apb and the typical rc period
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected at %0t ns: got %h expected %h", $time, (g), (e)); end end
module tb_adc_conversion_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, pins = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, adc_en, hold, cmp, irq, mask_on;
   logic [2:0] chan;
   logic [9:0] dac;
   // levels stand for the channel pins, whatever their direction or configuration
   logic [7:0][9:0] levels = '0;
   logic [15:0] rnd = 16'h0039;
   int err_total = 0, check_count = 0, low_cnt = 0, last_low = 0, runs = 0;
   // analog pins per port configuration, entry 0 first
   localparam logic [7:0] AMAP [16] = '{8'hff, 8'hff, 8'h1f, 8'h1f, 8'h0b, 8'h0b, 8'h00, 8'h00,
                                        8'hff, 8'h3f, 8'h3f, 8'h3f, 8'h1f, 8'h0f, 8'h01, 8'h0d};
   always #12.5 mclk = ~mclk;
   acs_sequencer dut (.i_mclk(mclk), .i_reset_n(reset_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .o_adc_enable(adc_en), .o_channel_sel(chan), .o_hold_connect(hold),
      .o_dac_code(dac), .i_cmp_above(cmp), .i_pin_level(pins), .o_irq(irq));
   acs_analog_model front (.i_mclk(mclk), .i_hold_connect(hold), .i_channel_sel(chan),
      .i_dac_code(dac), .i_levels(levels), .o_cmp_above(cmp));
   // length of each disconnected stretch, conversion plus gap
   always @(posedge mclk) begin
      if (hold === 1'b0) begin
         low_cnt <= low_cnt + 1;
      end else if (low_cnt != 0) begin
         last_low <= low_cnt;
         runs <= runs + 1;
         low_cnt <= 0;
      end
   end
   function automatic logic [15:0] lfsr_step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic int tad_of(input logic [2:0] sel);
      case (sel)
         3'h0: return 2;
         3'h4: return 4;
         3'h1: return 8;
         3'h5: return 16;
         3'h2: return 32;
         3'h6: return 64;
         default: return acs_pkg::RC_TAD_STD_NS / acs_pkg::CLK_PERIOD_NS;
      endcase
   endfunction
   task automatic end_of_test();
      if (err_total == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         err_total++;
         end_of_test();
      end
      @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      `CHK(r, exp);
      `CHK(e, 1'b0);
   endtask
   task automatic wait_run(input int r0);
      int n;
      n = 0;
      while (runs == r0 && n < 4000) begin
         @(posedge mclk);
         n++;
      end
      if (runs == r0) begin
         err_total++;
         end_of_test();
      end
   endtask
   task automatic convert(input logic [2:0] sel, input logic fmt, input logic [2:0] ch,
                          input logic [9:0] v);
      int r0;
      levels[ch] <= v;
      wr(acs_pkg::OFS_CTRL1, {fmt, sel[2], 2'b00, rnd[3:0]});
      wr(acs_pkg::OFS_CTRL0, {sel[1:0], ch, 3'b001});
      wr(acs_pkg::OFS_MASK, {7'h0, mask_on});
      repeat (8) @(posedge mclk);
      r0 = runs;
      wr(acs_pkg::OFS_CTRL0, {sel[1:0], ch, 3'b101});
      wait_run(r0);
      `CHK(last_low, 14 * tad_of(sel));
      `CHK(irq, mask_on);
      `CHK(adc_en, 1'b1);
      rd_chk(acs_pkg::OFS_CTRL0, {24'h0, sel[1:0], ch, 3'b001});
      rd_chk(acs_pkg::OFS_STAT, 32'h1);
      rd_chk(acs_pkg::OFS_STAT, 32'h0);
      `CHK(irq, 1'b0);
      rd_chk(acs_pkg::OFS_RESH, fmt ? {30'h0, v[9:8]} : {24'h0, v[9:2]});
      rd_chk(acs_pkg::OFS_RESL, fmt ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h0});
   endtask
   initial begin
      logic [31:0] r;
      logic e;
      int r0;
      logic [7:0] p;
      mask_on = 1'b0;
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      rd_chk(acs_pkg::OFS_CTRL0, 32'h0);
      rd_chk(acs_pkg::OFS_CTRL1, 32'h0);
      rd_chk(acs_pkg::OFS_STAT, 32'h0);
      `CHK({irq, adc_en, hold}, 3'b000);
      // start with the converter off is ignored, unused bits read zero
      wr(acs_pkg::OFS_CTRL0, 8'hfe);
      rd_chk(acs_pkg::OFS_CTRL0, 32'hf8);
      `CHK(hold, 1'b0);
      wr(acs_pkg::OFS_CTRL1, 8'hff);
      rd_chk(acs_pkg::OFS_CTRL1, 32'hcf);
      wr(acs_pkg::OFS_STAT, 8'h01);
      rd_chk(acs_pkg::OFS_STAT, 32'h0);
      apb(1'b0, 8'h1c, 32'h0, r, e);
      `CHK({e, r}, 33'h100000000);
      wr(acs_pkg::OFS_RESH, 8'h5a);
      rd_chk(acs_pkg::OFS_RESH, 32'h5a);
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr_step(rnd);
         p = rnd[7:0];
         wr(acs_pkg::OFS_CTRL1, i[7:0]);
         pins <= p;
         rd_chk(acs_pkg::OFS_PORT, {24'h0, p & ~AMAP[i]});
      end
      for (int i = 0; i < 20; i++) begin
         rnd = lfsr_step(rnd);
         mask_on = rnd[4];
         // fast selects only time the sequence; the model settles at once
         convert(i < 8 ? i[2:0] : rnd[2:0], rnd[5], rnd[8:6],
                 i == 0 ? 10'h000 : (i == 1 ? 10'h3ff : rnd[15:6]));
      end
      // abort in mid-conversion keeps the old result and raises no flag
      wr(acs_pkg::OFS_RESH, 8'ha5);
      wr(acs_pkg::OFS_RESL, 8'h3c);
      r0 = runs;
      wr(acs_pkg::OFS_CTRL0, 8'h8d);
      repeat (200) @(posedge mclk);
      wr(acs_pkg::OFS_CTRL0, 8'h89);
      wait_run(r0);
      rd_chk(acs_pkg::OFS_STAT, 32'h0);
      rd_chk(acs_pkg::OFS_RESH, 32'ha5);
      rd_chk(acs_pkg::OFS_RESL, 32'h3c);
      end_of_test();
   end
endmodule
